// ==== src/asg_pkg.sv ====
package asg_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [11:0] ADDR_CAP0      = 12'h000;
    localparam logic [11:0] ADDR_CAP5      = 12'h004;
    localparam logic [11:0] ADDR_SCAP3     = 12'h008;
    localparam logic [11:0] ADDR_CTRL      = 12'h00C;
    localparam logic [11:0] ADDR_EVENTS    = 12'h010;
    localparam logic [11:0] ADDR_INV_CMD   = 12'h014;
    localparam logic [11:0] ADDR_INV_STAT  = 12'h018;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CAP0_ATS_BIT     = 0;
    localparam int CAP0_PRI_BIT     = 1;
    localparam int SCAP3_SECURE_ATS_COMMANDS_SUPPORTED_BIT   = 0;
    localparam int CTRL_EN_BIT      = 0;
    localparam int CTRL_SECCMD_BIT  = 1;
    localparam int EV_BADSUB_BIT    = 0;
    localparam int EV_TFORBID_BIT   = 1;
    localparam int EV_BADTREQ_BIT   = 2;
    localparam int EV_CMDERR_BIT    = 3;
    localparam int INV_SEC_BIT      = 31;
    localparam int INV_PRI_BIT      = 30;
    localparam int INVST_BUSY_BIT   = 0;
    localparam int INVST_DONE_BIT   = 1;

    // ----------------------------------------------------------------
    // Reset values and widths
    // ----------------------------------------------------------------
    localparam logic [1:0]  CTRL_RESET  = 2'h0;
    localparam int          PASID_MAX_W = 20;
    localparam int          GRANULE_LOG2_DEFAULT = 12;

    typedef enum logic [1:0] {
        ASG_CPL_OK,
        ASG_CPL_FAIL,
        ASG_CPL_UR
    } asg_cpl_t;

    typedef enum logic [1:0] {
        ASG_INV_IDLE,
        ASG_INV_SEND,
        ASG_INV_WAIT
    } asg_inv_state_t;

endpackage

// ==== src/asg_gateway.sv ====
`timescale 1ns/1ps
// What this block does
// - Requester identity forms low stream identifier bits.
// - Substream without stage 1 aborts, logs event.
// - Substream path carries PASIDs up to twenty bits.
// - Oversized PASID is truncated, not flagged.
// - Substream valid flag accompanies every transaction.
// - No PASID means data, unprivileged access.
// - PASID execute/privileged drive instruction, privileged attributes.
// - Read-only ATS and dependent page request capability.
// - Good translation returns success with address.
// - Faulting translation returns negative completion.
// - Grant only permissions available for page.
// - Failed ATS translations record no fault event.
// - Invalidations forwarded; completion waits for responses.
// - Secure entries ignore endpoint ATS mode.
// - Invalidate and page response target Secure only with SEC_ATS_CMDS and CTRL bit 1 set.
// - Translated traffic on Secure stream aborts, logs event.
// - Secure translation request gets Unsupported Request, logged.
// - Secure request check precedes range and lookup.
// - Secure queue ATS commands advertised by capability.
// - Smallest translation unit equals smallest granule.
module asg_gateway #(
    parameter int RID_W        = 16,
    parameter int SID_W        = 24,
    parameter int SSID_W       = 20,
    parameter int OA_W         = 48,
    parameter bit ATS_IMPL     = 1'b1,
    parameter bit PRI_IMPL     = 1'b1,
    parameter bit SEC_ATS_CMDS = 1'b0,
    parameter int GRANULE_LOG2 = asg_pkg::GRANULE_LOG2_DEFAULT
) (
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    // APB slave.
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [11:0]                  paddr,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    // Incoming transactions from the root complex.
    input  wire logic                         txn_valid,
    output logic                              txn_ready,
    input  wire logic [RID_W-1:0]             txn_rid,
    input  wire logic [SID_W-RID_W-1:0]       txn_seg,
    input  wire logic                         txn_secure,
    input  wire logic                         txn_ssid_valid,
    input  wire logic [asg_pkg::PASID_MAX_W-1:0] txn_pasid,
    input  wire logic                         txn_pasid_exe,
    input  wire logic                         txn_pasid_privileged_attr,
    input  wire logic                         txn_write,
    input  wire logic                         txn_translated,
    input  wire logic                         txn_treq,
    input  wire logic [2:0]                   txn_req_perm,
    // Configuration lookup answer for the presented stream.
    input  wire logic                         cfg_stage1,
    input  wire logic                         cfg_sid_ok,
    input  wire logic [1:0]                   cfg_endpoint_ats_mode,
    // Translation result for the presented request.
    input  wire logic                         xl_hit,
    input  wire logic [OA_W-1:0]              xl_addr,
    input  wire logic [2:0]                   xl_perm,
    // Forwarded transaction with attributes.
    output logic                              fwd_valid,
    input  wire logic                         fwd_ready,
    output logic [SID_W-1:0]                  fwd_sid,
    output logic [SSID_W-1:0]                 fwd_ssid,
    output logic                              fwd_ssid_valid,
    output logic                              fwd_instruction_attr,
    output logic                              fwd_privileged_attr,
    output logic                              fwd_write,
    output logic                              fwd_bypass,
    // Translation completion back to the root complex.
    output logic                              cpl_valid,
    input  wire logic                         cpl_ready,
    output logic [1:0]                        cpl_status,
    output logic [OA_W-1:0]                   cpl_addr,
    output logic [2:0]                        cpl_perm,
    output logic                              cpl_global,
    // Abort of a plain transaction.
    output logic                              abort_pulse,
    // Endpoint invalidation link.
    output logic                              inv_valid,
    input  wire logic                         inv_ready,
    output logic [SID_W-1:0]                  inv_sid,
    output logic                              inv_is_page_resp,
    input  wire logic                         inv_resp
);
    import asg_pkg::*;

    initial begin
        if (SSID_W < 1 || SSID_W > PASID_MAX_W || RID_W >= SID_W || SID_W > 29)
            $error("asg_gateway: unsupported width parameters");
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [1:0]         ctrl;
    logic [3:0]         events;
    logic               inv_busy;
    logic               inv_done;
    logic [SID_W-1:0]   inv_sid_r;
    logic               inv_pr_r;
    asg_inv_state_t     inv_state;

    wire  apb_acc = psel & penable;
    wire  apb_wr  = apb_acc & pwrite;
    wire  ats_on  = ATS_IMPL & ctrl[CTRL_EN_BIT];

    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    always_comb begin
        prdata = 32'h00000000;
        case (paddr)
            ADDR_CAP0: begin
                prdata[CAP0_ATS_BIT] = ATS_IMPL;
                prdata[CAP0_PRI_BIT] = ATS_IMPL & PRI_IMPL;
            end
            ADDR_CAP5:     prdata[4:0] = 5'(GRANULE_LOG2);
            ADDR_SCAP3:    prdata[SCAP3_SECURE_ATS_COMMANDS_SUPPORTED_BIT] = SEC_ATS_CMDS;
            ADDR_CTRL:     prdata[1:0] = ctrl;
            ADDR_EVENTS:   prdata[3:0] = events;
            ADDR_INV_CMD:  prdata[SID_W-1:0] = inv_sid_r;
            ADDR_INV_STAT: begin
                prdata[INVST_BUSY_BIT] = inv_busy;
                prdata[INVST_DONE_BIT] = inv_done;
            end
            default:       prdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RESET;
        end else if (apb_wr && paddr == ADDR_CTRL) begin
            ctrl <= pwdata[1:0];
        end
    end

    // ----------------------------------------------------------------
    // Transaction classification
    // ----------------------------------------------------------------
    logic [SID_W-1:0]  sid;
    logic [SSID_W-1:0] ssid;
    logic              sec_treq;
    logic              sec_transl;
    logic              bad_sub;
    logic              ats_allowed;
    logic              busy_out;

    assign sid  = {txn_seg, txn_rid};
    assign ssid = txn_pasid[SSID_W-1:0];
    // Secure streams never see endpoint ATS mode, whatever is stored.
    assign ats_allowed = ats_on & ~txn_secure & (cfg_endpoint_ats_mode != 2'h0);
    assign sec_treq    = txn_treq & txn_secure;
    assign sec_transl  = txn_translated & txn_secure & ~txn_treq;
    assign bad_sub     = txn_ssid_valid & ~cfg_stage1;

    assign busy_out  = (cpl_valid & ~cpl_ready) | (fwd_valid & ~fwd_ready);
    assign txn_ready = ~busy_out;
    wire   take      = txn_valid & txn_ready;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpl_valid  <= 1'b0;
            cpl_status <= 2'h0;
            cpl_addr   <= '0;
            cpl_perm   <= 3'h0;
            cpl_global <= 1'b0;
        end else if (take && txn_treq) begin
            cpl_valid  <= 1'b1;
            cpl_global <= 1'b0;
            cpl_addr   <= '0;
            cpl_perm   <= 3'h0;
            if (sec_treq) begin
                cpl_status <= ASG_CPL_UR;
            end else if (!cfg_sid_ok || !ats_allowed || bad_sub || !xl_hit
                         || (xl_perm & txn_req_perm) == 3'h0) begin
                cpl_status <= ASG_CPL_FAIL;
            end else begin
                cpl_status <= ASG_CPL_OK;
                cpl_addr   <= xl_addr;
                cpl_perm   <= xl_perm & txn_req_perm;
            end
        end else if (cpl_ready) begin
            cpl_valid <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fwd_valid            <= 1'b0;
            fwd_sid              <= '0;
            fwd_ssid             <= '0;
            fwd_ssid_valid       <= 1'b0;
            fwd_instruction_attr <= 1'b0;
            fwd_privileged_attr  <= 1'b0;
            fwd_write            <= 1'b0;
            fwd_bypass           <= 1'b0;
        end else if (take && !txn_treq && !sec_transl && !bad_sub && cfg_sid_ok) begin
            fwd_valid            <= 1'b1;
            fwd_sid              <= sid;
            fwd_ssid_valid       <= txn_ssid_valid;
            fwd_ssid             <= txn_ssid_valid ? ssid : '0;
            fwd_instruction_attr <= txn_ssid_valid & txn_pasid_exe;
            fwd_privileged_attr  <= txn_ssid_valid & txn_pasid_privileged_attr;
            fwd_write            <= txn_write;
            fwd_bypass           <= txn_translated & ats_allowed;
        end else if (fwd_ready) begin
            fwd_valid <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            abort_pulse <= 1'b0;
        end else begin
            abort_pulse <= take & ~txn_treq & (sec_transl | bad_sub | ~cfg_sid_ok);
        end
    end

    // ----------------------------------------------------------------
    // Event flags: hardware set wins over a write-one-to-clear.
    // ----------------------------------------------------------------
    logic [3:0] ev_set;
    logic       cmd_err;

    always_comb begin
        ev_set = 4'h0;
        ev_set[EV_BADSUB_BIT]  = take & ~txn_treq & ~sec_transl & bad_sub;
        ev_set[EV_TFORBID_BIT] = take & sec_transl;
        ev_set[EV_BADTREQ_BIT] = take & sec_treq;
        ev_set[EV_CMDERR_BIT]  = cmd_err;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            events <= 4'h0;
        end else begin
            events <= (events & ~((apb_wr && paddr == ADDR_EVENTS) ? pwdata[3:0] : 4'h0))
                      | ev_set;
        end
    end

    // ----------------------------------------------------------------
    // Endpoint invalidation and page response forwarding
    // ----------------------------------------------------------------
    wire inv_wr  = apb_wr && paddr == ADDR_INV_CMD && !inv_busy;
    wire sec_ok  = ~pwdata[INV_SEC_BIT] | (SEC_ATS_CMDS & ctrl[CTRL_SECCMD_BIT]);
    // A Secure target is refused unless SEC_ATS_CMDS and the CTRL secure-command bit are both set.
    wire inv_bad = pwdata[SID_W] | ~sec_ok;
    assign cmd_err = inv_wr & inv_bad;

    assign inv_valid        = (inv_state == ASG_INV_SEND);
    assign inv_sid          = inv_sid_r;
    assign inv_is_page_resp = inv_pr_r;
    assign inv_busy         = (inv_state != ASG_INV_IDLE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inv_state <= ASG_INV_IDLE;
            inv_sid_r <= '0;
            inv_pr_r  <= 1'b0;
            inv_done  <= 1'b0;
        end else begin
            case (inv_state)
                ASG_INV_IDLE: begin
                    if (inv_wr && !inv_bad) begin
                        inv_sid_r <= pwdata[SID_W-1:0];
                        inv_pr_r  <= pwdata[INV_PRI_BIT];
                        inv_done  <= 1'b0;
                        inv_state <= ASG_INV_SEND;
                    end
                end
                ASG_INV_SEND: begin
                    if (inv_ready) begin
                        inv_state <= inv_pr_r ? ASG_INV_IDLE : ASG_INV_WAIT;
                        inv_done  <= inv_pr_r;
                    end
                end
                ASG_INV_WAIT: begin
                    // Completion only once the responses have come back.
                    if (inv_resp) begin
                        inv_done  <= 1'b1;
                        inv_state <= ASG_INV_IDLE;
                    end
                end
                default: inv_state <= ASG_INV_IDLE;
            endcase
        end
    end

endmodule

// ==== tb/asg_gateway_properties.sv ====
`timescale 1ns/1ps
module asg_gateway_properties
    import asg_pkg::*;
#(
    parameter int RID_W  = 16,
    parameter int SID_W  = 24,
    parameter int SSID_W = 20
) (
    input wire logic                               pclk,
    input wire logic                               presetn,
    input wire logic                               txn_valid,
    input wire logic                               txn_ready,
    input wire logic [RID_W-1:0]                   txn_rid,
    input wire logic                               txn_secure,
    input wire logic                               txn_ssid_valid,
    input wire logic [asg_pkg::PASID_MAX_W-1:0]    txn_pasid,
    input wire logic                               txn_pasid_exe,
    input wire logic                               txn_pasid_privileged_attr,
    input wire logic                               txn_translated,
    input wire logic                               txn_treq,
    input wire logic [2:0]                         txn_req_perm,
    input wire logic                               cfg_stage1,
    input wire logic                               cfg_sid_ok,
    input wire logic                               xl_hit,
    input wire logic [2:0]                         xl_perm,
    input wire logic                               fwd_valid,
    input wire logic [SID_W-1:0]                   fwd_sid,
    input wire logic [SSID_W-1:0]                  fwd_ssid,
    input wire logic                               fwd_ssid_valid,
    input wire logic                               fwd_instruction_attr,
    input wire logic                               fwd_privileged_attr,
    input wire logic                               cpl_valid,
    input wire logic                               cpl_ready,
    input wire logic [1:0]                         cpl_status,
    input wire logic [2:0]                         cpl_perm,
    input wire logic                               abort_pulse,
    input wire logic                               inv_valid,
    input wire logic                               inv_ready,
    input wire logic [SID_W-1:0]                   inv_sid
);
    logic acc;
    logic plain;
    assign acc   = txn_valid && txn_ready;
    assign plain = acc && !txn_treq && !txn_translated && cfg_sid_ok;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    secure_treq_ur_a: assert property (
        acc && txn_treq && txn_secure |=> cpl_valid && cpl_status == ASG_CPL_UR)
        else $error("secure translation request not refused");
    sid_map_a: assert property (
        plain && !txn_ssid_valid |=> fwd_valid && !fwd_ssid_valid && !fwd_instruction_attr
        && !fwd_privileged_attr && fwd_sid[RID_W-1:0] == $past(txn_rid))
        else $error("plain transaction forwarded wrongly");
    bad_substream_a: assert property (
        plain && txn_ssid_valid && !cfg_stage1 |=> abort_pulse && !fwd_valid)
        else $error("substream without stage one not aborted");
    pasid_attr_a: assert property (
        plain && txn_ssid_valid && cfg_stage1 |=> fwd_valid && fwd_ssid_valid
        && fwd_ssid == $past(txn_pasid[SSID_W-1:0])
        && {fwd_instruction_attr, fwd_privileged_attr} == $past({txn_pasid_exe, txn_pasid_privileged_attr}))
        else $error("substream attributes forwarded wrongly");
    secure_translated_a: assert property (
        acc && !txn_treq && txn_translated && txn_secure |=> abort_pulse && !fwd_valid)
        else $error("translated secure traffic not aborted");
    treq_miss_a: assert property (
        acc && txn_treq && !txn_secure && !xl_hit |=> cpl_valid && cpl_status == ASG_CPL_FAIL
        && !abort_pulse)
        else $error("missed translation not answered negatively");
    grant_subset_a: assert property (
        acc && txn_treq && !txn_secure && xl_hit |=> cpl_status != ASG_CPL_OK
        || cpl_perm == ($past(txn_req_perm) & $past(xl_perm)))
        else $error("granted permissions exceed the page");
    cpl_hold_a: assert property (
        cpl_valid && !cpl_ready |=> cpl_valid && $stable(cpl_status) && $stable(cpl_perm))
        else $error("completion dropped before acceptance");
    inv_hold_a: assert property (
        inv_valid && !inv_ready |=> inv_valid && $stable(inv_sid))
        else $error("invalidation dropped before acceptance");
endmodule

bind asg_gateway asg_gateway_properties #(.RID_W(RID_W), .SID_W(SID_W), .SSID_W(SSID_W))
    u_asg_gateway_properties (.pclk, .presetn, .txn_valid, .txn_ready, .txn_rid, .txn_secure,
    .txn_ssid_valid, .txn_pasid, .txn_pasid_exe, .txn_pasid_privileged_attr, .txn_translated, .txn_treq,
    .txn_req_perm, .cfg_stage1, .cfg_sid_ok, .xl_hit, .xl_perm, .fwd_valid, .fwd_sid, .fwd_ssid,
    .fwd_ssid_valid, .fwd_instruction_attr, .fwd_privileged_attr, .cpl_valid, .cpl_ready,
    .cpl_status, .cpl_perm, .abort_pulse, .inv_valid, .inv_ready, .inv_sid);

// ==== tb/asg_rc_model.sv ====
`timescale 1ns/1ps
module asg_rc_model #(
    parameter int RESP_DLY = 6
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        stall,
    input  wire logic        inv_valid,
    input  wire logic        inv_is_page_resp,
    input  wire logic [23:0] inv_sid,
    output logic             cpl_ready,
    output logic             fwd_ready,
    output logic             inv_ready,
    output logic             inv_resp,
    output logic [23:0]      last_sid
);
    int unsigned wait_cnt;
    // A stalled root complex holds back every kind of traffic at once.
    assign cpl_ready = !stall;
    assign fwd_ready = !stall;
    assign inv_ready = !stall;
    // Endpoint responses are collected for a while before the answer comes back.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_cnt <= 0;
            inv_resp <= 1'b0;
            last_sid <= 24'h0;
        end else begin
            inv_resp <= (wait_cnt == 1);
            if (inv_valid && inv_ready) begin
                last_sid <= inv_sid;
                wait_cnt <= inv_is_page_resp ? 0 : RESP_DLY;
            end else if (wait_cnt != 0) begin
                wait_cnt <= wait_cnt - 1;
            end
        end
    end
endmodule

// ==== tb/tb_asg_gateway.sv ====
`timescale 1ns/1ps
module tb_asg_gateway;
    import asg_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, stall, txn_valid, txn_ready;
    logic txn_secure, txn_ssid_valid, txn_pasid_exe, txn_pasid_privileged_attr, txn_write, txn_translated;
    logic txn_treq, cfg_stage1, cfg_sid_ok, xl_hit, fwd_valid, fwd_ready, fwd_ssid_valid;
    logic fwd_instruction_attr, fwd_privileged_attr, fwd_write, fwd_bypass, cpl_valid, cpl_ready;
    logic cpl_global, abort_pulse, inv_valid, inv_ready, inv_is_page_resp, inv_resp;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] txn_rid;
    logic [7:0]  txn_seg, fwd_ssid;
    logic [19:0] txn_pasid;
    logic [2:0]  txn_req_perm, xl_perm, cpl_perm;
    logic [1:0]  cfg_endpoint_ats_mode, cpl_status;
    logic [47:0] xl_addr, cpl_addr;
    logic [23:0] fwd_sid, inv_sid, last_sid;
    logic [11:0] ra [4] = '{ADDR_CAP0, ADDR_CAP5, ADDR_SCAP3, 12'h020};
    logic [31:0] re [4] = '{32'h3, 32'hC, 32'h0, 32'h0};
    int errors, check_count, n;

    asg_gateway #(.SSID_W(8)) u_asg_gateway (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .txn_valid, .txn_ready, .txn_rid, .txn_seg,
        .txn_secure, .txn_ssid_valid, .txn_pasid, .txn_pasid_exe, .txn_pasid_privileged_attr, .txn_write,
        .txn_translated, .txn_treq, .txn_req_perm, .cfg_stage1, .cfg_sid_ok,
        .cfg_endpoint_ats_mode, .xl_hit, .xl_addr, .xl_perm, .fwd_valid, .fwd_ready, .fwd_sid,
        .fwd_ssid, .fwd_ssid_valid, .fwd_instruction_attr, .fwd_privileged_attr, .fwd_write,
        .fwd_bypass, .cpl_valid, .cpl_ready, .cpl_status, .cpl_addr, .cpl_perm, .cpl_global,
        .abort_pulse, .inv_valid, .inv_ready, .inv_sid, .inv_is_page_resp, .inv_resp);
    asg_rc_model u_asg_rc_model (.pclk, .presetn, .stall, .inv_valid, .inv_is_page_resp,
        .inv_sid, .cpl_ready, .fwd_ready, .inv_ready, .inv_resp, .last_sid);

    // ----------------------------------------------------------------
    // Access tasks
    // ----------------------------------------------------------------
    task automatic end_of_test;
        if (errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Waits for ready at a rising edge; read data is taken at that same edge.
    task automatic wait_hi(input bit on_txn);
        int k;
        k = 0;
        do begin
            @(posedge pclk);
            rd = prdata;
            k++;
        end while ((on_txn ? txn_ready : pready) !== 1'b1 && k < 40);
        if ((on_txn ? txn_ready : pready) !== 1'b1) begin
            errors++;
            end_of_test();
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        wait_hi(1'b0);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Event register is read, compared and then cleared by writing ones.
    task automatic ev(input logic [31:0] exp);
        apb(1'b0, ADDR_EVENTS, 32'h0);
        chk(rd, exp);
        apb(1'b1, ADDR_EVENTS, 32'hF);
    endtask

    // Flags are {secure, substream valid, translated, request, stage one, stream ok}.
    task automatic xfer(input logic [5:0] f, input logic [19:0] pas, input logic [2:0] xp);
        @(posedge pclk);
        {txn_secure, txn_ssid_valid, txn_translated, txn_treq, cfg_stage1, cfg_sid_ok} <= f;
        txn_pasid <= pas;
        txn_pasid_exe <= pas[0];
        txn_pasid_privileged_attr <= pas[1];
        txn_write <= pas[2];
        xl_addr <= {28'h0ABCDEF, pas};
        xl_perm <= xp;
        xl_hit <= |xp;
        txn_valid <= 1'b1;
        wait_hi(1'b1);
        txn_valid <= 1'b0;
        #1;
    endtask

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, txn_valid, txn_secure, txn_ssid_valid,
         txn_pasid, txn_pasid_exe, txn_pasid_privileged_attr, txn_write, txn_translated, txn_treq,
         cfg_stage1, cfg_sid_ok, xl_hit, xl_addr, xl_perm, stall} = '0;
        txn_rid = 16'hA5C3;
        txn_seg = 8'h7E;
        txn_req_perm = 3'b011;
        cfg_endpoint_ats_mode = 2'h1;
        errors = 0;
        check_count = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ra[i]) begin
            apb(1'b1, ra[i], 32'hFFFF_FFFF);
            apb(1'b0, ra[i], 32'h0);
            chk({pslverr, rd}, {1'b0, re[i]});
        end
        apb(1'b1, ADDR_CTRL, 32'h1);
        xfer(6'b000001, 20'h0, 3'b000);
        chk({fwd_valid, fwd_ssid_valid, fwd_instruction_attr, fwd_privileged_attr, fwd_write,
            fwd_bypass, fwd_sid}, {6'b100000, 24'h7EA5C3});
        xfer(6'b010011, 20'hABCDE, 3'b000);
        chk({fwd_valid, fwd_ssid_valid, fwd_instruction_attr, fwd_privileged_attr, fwd_write,
            fwd_ssid}, {5'b11011, 8'hDE});
        xfer(6'b010011, 20'h00001, 3'b000);
        chk({fwd_instruction_attr, fwd_privileged_attr, fwd_ssid}, {2'b10, 8'h01});
        xfer(6'b001001, 20'h0, 3'b000);
        chk({fwd_valid, fwd_bypass, abort_pulse}, 3'b110);
        ev(32'h0);
        xfer(6'b010001, 20'h00005, 3'b000);
        chk({abort_pulse, fwd_valid}, 2'b10);
        ev(32'h1);
        xfer(6'b101001, 20'h0, 3'b000);
        chk({abort_pulse, fwd_valid}, 2'b10);
        ev(32'h2);
        xfer(6'b100100, 20'h0, 3'b111);
        chk({cpl_valid, cpl_status}, {1'b1, 2'h2});
        ev(32'h4);
        xfer(6'b000101, 20'h00010, 3'b101);
        chk({cpl_valid, cpl_status, cpl_perm, cpl_global, cpl_addr},
            {7'b1000010, 48'h0ABCDEF00010});
        xfer(6'b000101, 20'h0, 3'b000);
        chk({cpl_valid, cpl_status, abort_pulse}, 4'b1010);
        ev(32'h0);
        @(posedge pclk);
        stall <= 1'b1;
        xfer(6'b000101, 20'h0, 3'b011);
        repeat (3) @(posedge pclk);
        #1;
        chk({cpl_valid, txn_ready}, 2'b10);
        // Internal TLB maintenance is taken as complete before the endpoint invalidation.
        apb(1'b1, ADDR_INV_CMD, 32'h0000_0123);
        apb(1'b0, ADDR_INV_STAT, 32'h0);
        chk(rd, 32'h1);
        stall <= 1'b0;
        n = 0;
        do begin
            apb(1'b0, ADDR_INV_STAT, 32'h0);
            n++;
        end while (rd[INVST_DONE_BIT] !== 1'b1 && n < 20);
        chk(rd, 32'h2);
        chk(last_sid, 24'h000123);
        apb(1'b1, ADDR_INV_CMD, 32'h8000_0123);
        #1;
        chk(inv_valid, 1'b0);
        ev(32'h8);
        apb(1'b1, ADDR_INV_CMD, 32'h4000_0042);
        #1;
        chk({inv_valid, inv_is_page_resp}, 2'b11);
        apb(1'b0, ADDR_INV_STAT, 32'h0);
        chk({rd, last_sid}, {32'h2, 24'h000042});
        // Endpoint ATS is taken as already off before translation is switched off.
        apb(1'b1, ADDR_CTRL, 32'h0);
        xfer(6'b000101, 20'h0, 3'b101);
        chk({cpl_valid, cpl_status}, 3'b101);
        end_of_test();
    end
endmodule
